// ### verification/microcontroller_port_strobe_decoder_test.sv
// Self-checking bench for the port strobe decoder
`timescale 1ns/1ns
module microcontroller_port_strobe_decoder_test;
   import port_strobe_pkg::*;
   typedef struct packed {byte_t ext; logic ram; byte_t rd; byte_t wr;} row_t;
   localparam row_t ROWS [6] = '{'{8'h8B, 1'b0, 8'h08, 8'h01}, '{8'hF8, 1'b0, 8'h01, 8'h80},
      '{8'h5F, 1'b0, 8'h80, 8'h00}, '{8'hA4, 1'b0, 8'h00, 8'h04},
      '{8'hCE, 1'b1, 8'h00, 8'h00}, '{8'h00, 1'b0, 8'h00, 8'h00}};
   logic core_clk = 1'b0, rst_b, clkEn, ramSelect, marker, directionStrobe;
   logic portBusOe, ramCs_n, ramWe_n;
   logic [13:0] procAddrRev;
   logic [15:0] romWord, instrWordRev;
   logic [9:0] romAddr;
   logic [7:0] readStrobe, writeStrobe;
   byte_t extByte, procDataOutRev, portBusIn_n, srcData, bitPorts, portBusOut_n, procDataIn;
   byte_t outPort0;
   byte_t expBits = 8'h00;
   int err_count = 0, cmp_count = 0, cycles = 0;
   always #5 core_clk = ~core_clk;
   port_strobe_decoder u_dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
      .procAddrRev(procAddrRev), .romWord(romWord), .extByte(extByte), .ramSelect(ramSelect),
      .procDataOutRev(procDataOutRev), .portBusIn_n(portBusIn_n), .srcData(srcData),
      .romAddr(romAddr), .instrWordRev(instrWordRev), .marker(marker),
      .directionStrobe(directionStrobe), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
      .bitPorts(bitPorts), .portBusOut_n(portBusOut_n), .portBusOe(portBusOe),
      .procDataIn(procDataIn), .ramCs_n(ramCs_n), .ramWe_n(ramWe_n), .outPort0(outPort0));
   proc_side_model u_far (.core_clk(core_clk), .romAddr(romAddr), .readStrobe(readStrobe),
      .ramCs_n(ramCs_n), .ramWe_n(ramWe_n), .portBusOut_n(portBusOut_n), .romWord(romWord),
      .portBusIn_n(portBusIn_n));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Processor bit 0 is the board's most significant bit
   function automatic byte_t flip(input byte_t v);
      byte_t r;
      for (int i = 0; i < 8; i++) r[i] = v[7-i];
      return r;
   endfunction : flip
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // Hang guard: 200 instructions at most
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic wait_fall();
      int n;
      n = 0;
      @(negedge core_clk);
      while (marker !== 1'b1 && n < 60) begin @(negedge core_clk); n++; end
      while (marker !== 1'b0 && n < 60) begin @(negedge core_clk); n++; end
      chk(16'(n < 60), 16'h0001);
   endtask : wait_fall
   task automatic run_instr(input row_t r);
      int nMark, nDir, nWe;
      @(posedge core_clk);
      extByte <= r.ext;
      ramSelect <= r.ram;
      if (!r.ext[7]) expBits[r.ext[6:4]] = procDataOutRev[0];
      // Two sync stages, then capture at marker end: up to a full instruction before the new byte is in force
      repeat (2) wait_fall();
      nMark = 0; nDir = 0; nWe = 0;
      for (int t = 1; t <= 25; t++) begin
         @(negedge core_clk);
         nMark += marker; nDir += directionStrobe; nWe += !ramWe_n;
         if (t == 6) chk(readStrobe, r.rd);
         if (t == 6) chk(directionStrobe, 1'b0);
         if (t == 15) chk(writeStrobe, r.wr);
         if (t == 15) chk(portBusOe, 1'b1);
         if (t == 15) chk(ramCs_n, !r.ram);
         if (t == 15) chk(portBusOut_n, byte_t'(~flip(procDataOutRev)));
         if (t == 21 && r.wr[0]) chk(outPort0, flip(procDataOutRev));
         if (t == 15 && !r.ram) chk(procDataIn, (r.rd != 8'h00) ? 8'h87 : 8'h00);
         if (t == 21) chk(readStrobe | writeStrobe, 8'h00);
      end
      chk(nMark, 7);
      chk(nDir, 13);
      chk(nWe, r.ram);
      chk(bitPorts, expBits);
   endtask : run_instr
   initial begin
      rst_b = 1'b0; clkEn = 1'b1; procAddrRev = 14'h3ABC; extByte = 8'h00;
      ramSelect = 1'b0; procDataOutRev = 8'h01; srcData = 8'h5A;
      repeat (5) @(posedge core_clk);
      chk(portBusOut_n, 8'hFF);
      chk({ramCs_n, ramWe_n, marker}, 16'h0006);
      chk({readStrobe, writeStrobe}, 16'h0000);
      rst_b <= 1'b1;
      foreach (ROWS[i]) run_instr(ROWS[i]);
      chk(romAddr, procAddrRev[9:0]);
      chk(instrWordRev, {6'h00, procAddrRev[9:0]} ^ 16'hA5A5);
      @(posedge core_clk);
      procDataOutRev <= 8'h00;
      run_instr('{8'h50, 1'b0, 8'h00, 8'h00});
      @(posedge core_clk);
      clkEn <= 1'b0;
      repeat (40) @(posedge core_clk);
      chk(marker, 1'b0);
      clkEn <= 1'b1;
      run_instr('{8'hB9, 1'b0, 8'h02, 8'h08});
      @(posedge core_clk);
      rst_b <= 1'b0;
      @(negedge core_clk);
      chk({readStrobe, writeStrobe}, 16'h0000);
      chk(bitPorts, 8'h00);
      give_verdict();
   end
endmodule : microcontroller_port_strobe_decoder_test

// ### verification/proc_side_model.sv
// Far side model: program store, tri-state input source and one buffer RAM cell
`timescale 1ns/1ns
module proc_side_model #(
   parameter logic [7:0] SRC_VALUE = 8'h1E
) (
   input wire logic core_clk,
   input wire logic [9:0] romAddr,
   input wire logic [7:0] readStrobe,
   input wire logic ramCs_n,
   input wire logic ramWe_n,
   input wire logic [7:0] portBusOut_n,
   output logic [15:0] romWord,
   output logic [7:0] portBusIn_n
);
   logic [7:0] cell_q = 8'h00;
   assign romWord = {6'h00, romAddr} ^ 16'hA5A5;
   // Pull-ups hold the idle bus high
   assign portBusIn_n = (readStrobe != 8'h00) ? SRC_VALUE :
      (!ramCs_n && ramWe_n) ? ~cell_q : 8'hFF;
   always_ff @(posedge core_clk) begin
      if (!ramWe_n) begin
         cell_q <= ~portBusOut_n;
      end
   end
endmodule : proc_side_model

// ### verilog/one_of_eight.sv
// Registered 1-of-8 decoder with enable
`timescale 1ns/1ns
module one_of_eight (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic en,
   input wire port_strobe_pkg::sel_t sel,
   output logic [7:0] strobe
);
   import port_strobe_pkg::*;
   logic [7:0] dec;
   assign dec = en ? (8'h01 << sel) : 8'h00;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         strobe <= 8'h00;
      end else if (clkEn) begin
         strobe <= dec;
      end
   end
endmodule : one_of_eight

// ### verilog/port_strobe_consts.svh
// Constants for the port strobe decoder
`ifndef PORT_STROBE_CONSTS_SVH
`define PORT_STROBE_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define INSTR_PERIOD_NS 250
`define MARKER_PULSE_NS 65
`define MARKER_CYCLES ((`MARKER_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INSTR_CYCLES (`INSTR_PERIOD_NS / `CLK_PERIOD_NS)
`define HALF_CYCLES (`INSTR_CYCLES / 2)
`define EXT_RD_LSB 0
`define EXT_WR_LSB 4
`define EXT_WR_EN_BIT 7
`define EXT_RD_EN_BIT 3
`define EXT_BIT_SEL_BIT 7
`define IADDR_USED 10
`define IWORD_W 16
`define PORT_W 8
`define BITS_RESET 8'h00
`define OUT_RESET 8'h00
`endif

// ### verilog/port_strobe_decoder.sv
// Fast port select decoder and internal bus control
`timescale 1ns/1ns
`include "port_strobe_consts.svh"
module port_strobe_decoder #(
   parameter int ADDR_W = `IADDR_USED
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic [13:0] procAddrRev,
   input wire logic [`IWORD_W-1:0] romWord,
   input wire port_strobe_pkg::byte_t extByte,
   input wire logic ramSelect,
   input wire port_strobe_pkg::byte_t procDataOutRev,
   input wire port_strobe_pkg::byte_t portBusIn_n,
   input wire port_strobe_pkg::byte_t srcData,
   output logic [ADDR_W-1:0] romAddr,
   output logic [`IWORD_W-1:0] instrWordRev,
   output logic marker,
   output logic directionStrobe,
   output logic [7:0] readStrobe,
   output logic [7:0] writeStrobe,
   output port_strobe_pkg::byte_t bitPorts,
   output port_strobe_pkg::byte_t portBusOut_n,
   output logic portBusOe,
   output port_strobe_pkg::byte_t procDataIn,
   output logic ramCs_n,
   output logic ramWe_n,
   output port_strobe_pkg::byte_t outPort0
);
   import port_strobe_pkg::*;

   localparam logic [4:0] INSTR_LAST = 5'(`INSTR_CYCLES - 1);
   localparam logic [4:0] HALF = 5'(`HALF_CYCLES);
   localparam logic [4:0] MARK_START = 5'(`INSTR_CYCLES - `MARKER_CYCLES);

   // **********************************************
   // Bit order reversal
   // **********************************************
   function automatic byte_t rev8(input byte_t v);
      byte_t r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction : rev8

   // **********************************************
   // Input synchronisers
   // **********************************************
   byte_t extMeta_q, extSync_q;
   byte_t busMeta_q, busSync_q;
   byte_t srcMeta_q, srcSync_q;
   logic rbMeta_q, rbSync_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         extMeta_q <= 8'h00;
         extSync_q <= 8'h00;
         busMeta_q <= 8'hFF;
         busSync_q <= 8'hFF;
         srcMeta_q <= 8'h00;
         srcSync_q <= 8'h00;
         rbMeta_q <= 1'b0;
         rbSync_q <= 1'b0;
      end else if (clkEn) begin
         extMeta_q <= extByte;
         extSync_q <= extMeta_q;
         busMeta_q <= portBusIn_n;
         busSync_q <= busMeta_q;
         srcMeta_q <= srcData;
         srcSync_q <= srcMeta_q;
         rbMeta_q <= ramSelect;
         rbSync_q <= rbMeta_q;
      end
   end

   // **********************************************
   // Instruction timing
   // **********************************************
   logic [4:0] tick_q, tick_d;
   phase_t phase_q, phase_d;
   assign tick_d = (tick_q == INSTR_LAST) ? 5'h00 : tick_q + 5'h01;
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         PH_FIRST: if (tick_d == HALF) phase_d = PH_SECOND;
         PH_SECOND: if (tick_d == MARK_START) phase_d = PH_MARK;
         PH_MARK: if (tick_d == 5'h00) phase_d = PH_FIRST;
         default: phase_d = PH_FIRST;
      endcase
   end
   wire markEnd = (phase_q == PH_MARK) && (phase_d == PH_FIRST);
   wire secondHalf = (phase_d != PH_FIRST);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_q <= 5'h00;
         phase_q <= PH_FIRST;
      end else if (clkEn) begin
         tick_q <= tick_d;
         phase_q <= phase_d;
      end
   end

   // **********************************************
   // Extension byte capture
   // **********************************************
   // Held a whole instruction so strobes never glitch mid-cycle
   logic [3:0] wrLatch_q;
   sel_t rdSel_q;
   logic rdEn_q, bitVal_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrLatch_q <= 4'h0;
         rdSel_q <= 3'h0;
         rdEn_q <= 1'b0;
         bitVal_q <= 1'b0;
      end else if (clkEn && markEnd) begin
         wrLatch_q <= extSync_q[`EXT_WR_LSB +: 4];
         rdSel_q <= extSync_q[`EXT_RD_LSB +: 3];
         rdEn_q <= extSync_q[`EXT_RD_EN_BIT];
         bitVal_q <= procDataOutRev[0];
      end
   end
   wire sel_t wrSel = wrLatch_q[2:0];
   wire wrEn = wrLatch_q[3];
   wire leftBank = !rbSync_q;
   wire rdActive = leftBank && rdEn_q && !secondHalf && (phase_d != PH_MARK);
   wire wrActive = leftBank && wrEn && secondHalf && (phase_d != PH_MARK);
   // Bit ports use the write select as a latch address when write enable is clear
   wire bitActive = leftBank && !wrEn && (phase_d == PH_SECOND);

   logic [7:0] rdDec, wrDec;
   one_of_eight uRd (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .en(rdActive),
      .sel(rdSel_q),
      .strobe(rdDec)
   );
   assign readStrobe = rdDec;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         writeStrobe <= 8'h00;
      end else if (clkEn) begin
         writeStrobe <= wrActive ? (8'h01 << wrSel) : 8'h00;
      end
   end
   assign wrDec = writeStrobe;

   // **********************************************
   // Addressable bit latch
   // **********************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bitPorts <= `BITS_RESET;
      end else if (clkEn && bitActive) begin
         bitPorts[wrSel] <= bitVal_q;
      end
   end

   // **********************************************
   // Bus control and RAM
   // **********************************************
   byte_t heldSrc_q;
   logic wrPrev_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         heldSrc_q <= 8'h00;
         directionStrobe <= 1'b0;
         marker <= 1'b0;
         portBusOe <= 1'b0;
         portBusOut_n <= 8'hFF;
         procDataIn <= 8'h00;
         ramCs_n <= 1'b1;
         ramWe_n <= 1'b1;
         wrPrev_q <= 1'b0;
         outPort0 <= `OUT_RESET;
         romAddr <= '0;
         instrWordRev <= '0;
      end else if (clkEn) begin
         if (phase_d == PH_MARK) heldSrc_q <= srcSync_q;
         directionStrobe <= secondHalf;
         marker <= (phase_d == PH_MARK);
         portBusOe <= secondHalf;
         portBusOut_n <= ~rev8(procDataOutRev);
         if (!secondHalf) procDataIn <= rev8(~busSync_q);
         ramCs_n <= !rbSync_q;
         ramWe_n <= !(rbSync_q && wrPrev_q && !secondHalf);
         wrPrev_q <= secondHalf;
         // Latches what the processor drives, not the slow synchronised copy
         if (wrDec[0]) outPort0 <= ~portBusOut_n;
         romAddr <= procAddrRev[ADDR_W-1:0];
         if (phase_d == PH_MARK) instrWordRev <= romWord;
      end
   end

   // **********************************************
   // Checks
   // **********************************************
   AST_ONEHOT_RD: assert property (@(posedge core_clk) disable iff (!rst_b) $onehot0(readStrobe))
      else $error("multiple read strobes");
   AST_ONEHOT_WR: assert property (@(posedge core_clk) disable iff (!rst_b) $onehot0(writeStrobe))
      else $error("multiple write strobes");
   AST_RD_FIRST: assert property (@(posedge core_clk) disable iff (!rst_b) (readStrobe != 8'h00) |-> !directionStrobe)
      else $error("read strobe in second half");
   AST_WR_SECOND: assert property (@(posedge core_clk) disable iff (!rst_b) (writeStrobe != 8'h00) |-> directionStrobe)
      else $error("write without direction strobe");
   AST_MARK_RD: assert property (@(posedge core_clk) disable iff (!rst_b) marker |-> (readStrobe == 8'h00))
      else $error("read strobe during marker");
   AST_MARK_LEN: assert property (@(posedge core_clk) disable iff (!rst_b || !clkEn)
      $rose(marker) |-> marker[*7] ##1 !marker)
      else $error("marker width wrong");
   AST_OE: assert property (@(posedge core_clk) disable iff (!rst_b) portBusOe |-> directionStrobe)
      else $error("bus driven in first half");
   AST_PERIOD: assert property (@(posedge core_clk) disable iff (!rst_b || !clkEn) $rose(marker) |-> ##25 $rose(marker))
      else $error("instruction period wrong");
   AST_BANK_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
      ((readStrobe | writeStrobe) != 8'h00) |-> ramCs_n)
      else $error("left bank strobe during RAM access");
   AST_OE_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
      portBusOe == directionStrobe)
      else $error("bus enable differs from direction strobe");
endmodule : port_strobe_decoder

// ### verilog/port_strobe_pkg.sv
// Types for the port strobe decoder
package port_strobe_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] sel_t;
   typedef enum logic [1:0] {
      PH_FIRST = 2'b00,
      PH_SECOND = 2'b01,
      PH_MARK = 2'b10
   } phase_t;
endpackage : port_strobe_pkg
